/* include/result_status_pkg.sv */
// Purpose: constants and carriers for the result status bytes
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: byte selection codes are local to this block
package result_status_pkg;

    // ------------------------------------------------------------
    // completion codes
    // ------------------------------------------------------------
    localparam logic [1:0] CODE_NORMAL = 2'h0;
    localparam logic [1:0] CODE_ABNORMAL = 2'h1;
    localparam logic [1:0] CODE_INVALID = 2'h2;
    localparam logic [1:0] CODE_POLLING = 2'h3;

    // ------------------------------------------------------------
    // figures
    // ------------------------------------------------------------
    localparam int RECAL_STEP_LIMIT = 80;
    localparam logic [7:0] LAST_SECTOR_NUMBER = 8'hff;
    localparam logic [7:0] BAD_TRACK_NUMBER = 8'hff;
    localparam int RESULT_BYTE_COUNT = 4;

    // ------------------------------------------------------------
    // result byte selection
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_FIRST = 2'h0;
    localparam logic [1:0] SEL_SECOND = 2'h1;
    localparam logic [1:0] SEL_THIRD = 2'h2;
    localparam logic [1:0] SEL_FOURTH = 2'h3;

    // ------------------------------------------------------------
    // fixed bits of the fourth byte
    // ------------------------------------------------------------
    localparam logic FOURTH_FIXED_ONE = 1'b1;
    localparam logic UNUSED_ZERO = 1'b0;

    // ------------------------------------------------------------
    // byte layouts, msb first
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] completion_code;
        logic positioning_done;
        logic step_fault;
        logic unused3;
        logic head;
        logic [1:0] drive_number;
    } status_first_t;

    typedef struct packed {
        logic end_of_track;
        logic unused6;
        logic crc_fault;
        logic overrun;
        logic unused3;
        logic sector_missing;
        logic write_blocked;
        logic id_tag_absent;
    } status_second_t;

    typedef struct packed {
        logic unused7;
        logic deleted_flag_mismatch;
        logic data_field_crc_fault;
        logic track_mismatch;
        logic unused3;
        logic unused2;
        logic bad_track_flag;
        logic data_tag_absent;
    } status_third_t;

    typedef struct packed {
        logic unused7;
        logic write_protect_status;
        logic one5;
        logic track_zero_status;
        logic one3;
        logic head_select_status;
        logic [1:0] drive_number;
    } status_fourth_t;

    // ------------------------------------------------------------
    // event strobes from the command engine
    // ------------------------------------------------------------
    typedef struct packed {
        logic exec_abnormal;
        logic cmd_invalid;
        logic poll_abnormal;
        logic seek_done;
        logic recal_step;
        logic outward_past_zero;
        logic sector_access;
        logic rw_end_no_tc;
        logic id_crc_err;
        logic data_crc_err;
        logic service_late;
        logic sector_not_found;
        logic id_read_fail;
        logic track_sequence_err;
        logic write_cmd_active;
        logic no_id_after_two_index;
        logic no_data_tag;
        logic read_data_cmd;
        logic read_deleted_cmd;
        logic deleted_tag_seen;
        logic normal_tag_seen;
        logic id_track_valid;
    } status_events_t;

endpackage

/* hdl/pin_sync.sv */
// Purpose: two-flop synchroniser for drive cable inputs
// Assumes: single clock, synchronous reset
// Notes: first stage read only by second stage
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_reg;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            stage_reg <= '0;
            sync_out <= '0;
        end else begin
            stage_reg <= async_in;
            sync_out <= stage_reg;
        end
    end
endmodule
`default_nettype wire

/* hdl/disk_result_status_bytes.sv */
// Purpose: result status bytes of a disk controller core
// Assumes: command engine gives event strobes on sys_clk_in
// Notes: flags sticky per command, cleared at command start
`timescale 1ns/1ns
`default_nettype none
module disk_result_status_bytes
    import result_status_pkg::*;
#(
    parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // command engine
    input wire logic cmd_start_in,
    input wire logic recal_start_in,
    input wire logic result_phase_in,
    input wire logic [1:0] result_select_in,
    input wire status_events_t events_in,
    input wire logic [7:0] sector_number_in,
    input wire logic [7:0] id_track_in,
    input wire logic [7:0] internal_track_in,
    // drive selection and head
    input wire logic head_select_pin_in,
    input wire logic [1:0] drive_number_in,
    // drive cable inputs
    input wire logic write_protect_pin_in,
    input wire logic track_zero_pin_in,
    // host data port
    input wire logic host_read_in,
    output logic [7:0] result_data_out,
    output logic host_transfer_request_out,
    output logic transfer_direction_out,
    output logic result_done_out
);

    // ------------------------------------------------------------
    // cable input synchronisers
    // ------------------------------------------------------------
    logic [1:0] cable_sync;
    logic wp_sync;
    logic track_zero_pin_sync;

    pin_sync #(.WIDTH(2)) cable_sync_inst (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in({write_protect_pin_in, track_zero_pin_in}),
        .sync_out(cable_sync)
    );
    assign wp_sync = cable_sync[1];
    assign track_zero_pin_sync = cable_sync[0];

    // ------------------------------------------------------------
    // completion code
    // ------------------------------------------------------------
    logic [1:0] code_reg;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            code_reg <= CODE_NORMAL;
        end else if (events_in.cmd_invalid) begin
            code_reg <= CODE_INVALID;
        end else if (events_in.poll_abnormal) begin
            code_reg <= CODE_POLLING;
        end else if (events_in.exec_abnormal) begin
            code_reg <= CODE_ABNORMAL;
        end else if (cmd_start_in) begin
            code_reg <= CODE_NORMAL;
        end
    end

    // ------------------------------------------------------------
    // recalibrate step counter
    // ------------------------------------------------------------
    logic [7:0] step_count_reg;
    logic step_limit_hit;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            step_count_reg <= 8'h00;
        end else if (recal_start_in) begin
            step_count_reg <= 8'h00;
        end else if (events_in.recal_step && step_count_reg != 8'(STEP_LIMIT)) begin
            step_count_reg <= step_count_reg + 8'h01;
        end
    end

    assign step_limit_hit = events_in.recal_step && (step_count_reg == 8'(STEP_LIMIT - 1)) && !track_zero_pin_sync;

    // ------------------------------------------------------------
    // first byte flags
    // ------------------------------------------------------------
    logic seek_done_reg;
    logic step_fault_reg;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            seek_done_reg <= 1'b0;
        end else if (events_in.seek_done) begin
            seek_done_reg <= 1'b1;
        end else if (cmd_start_in) begin
            seek_done_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            step_fault_reg <= 1'b0;
        end else if (step_limit_hit || events_in.outward_past_zero) begin
            step_fault_reg <= 1'b1;
        end else if (cmd_start_in) begin
            step_fault_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // second byte flags
    // ------------------------------------------------------------
    logic end_track_reg;
    logic crc_fault_reg;
    logic overrun_reg;
    logic sector_missing_reg;
    logic write_blocked_reg;
    logic id_tag_absent_reg;
    logic beyond_last;

    assign beyond_last = events_in.sector_access && (sector_number_in == LAST_SECTOR_NUMBER);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            end_track_reg <= 1'b0;
        end else if (beyond_last || events_in.rw_end_no_tc) begin
            end_track_reg <= 1'b1;
        end else if (cmd_start_in) begin
            end_track_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            crc_fault_reg <= 1'b0;
        end else if (events_in.id_crc_err || events_in.data_crc_err) begin
            crc_fault_reg <= 1'b1;
        end else if (cmd_start_in) begin
            crc_fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            overrun_reg <= 1'b0;
        end else if (events_in.service_late) begin
            overrun_reg <= 1'b1;
        end else if (cmd_start_in) begin
            overrun_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sector_missing_reg <= 1'b0;
        end else if (events_in.sector_not_found || events_in.id_read_fail || events_in.track_sequence_err) begin
            sector_missing_reg <= 1'b1;
        end else if (cmd_start_in) begin
            sector_missing_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            write_blocked_reg <= 1'b0;
        end else if (events_in.write_cmd_active && wp_sync) begin
            write_blocked_reg <= 1'b1;
        end else if (cmd_start_in) begin
            write_blocked_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            id_tag_absent_reg <= 1'b0;
        end else if (events_in.no_id_after_two_index || events_in.no_data_tag) begin
            id_tag_absent_reg <= 1'b1;
        end else if (cmd_start_in) begin
            id_tag_absent_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // third byte flags
    // ------------------------------------------------------------
    logic mark_mismatch_reg;
    logic data_crc_reg;
    logic track_mismatch_reg;
    logic bad_track_reg;
    logic data_tag_absent_reg;
    logic mark_mismatch;
    logic track_differs;

    assign mark_mismatch = (events_in.read_data_cmd && events_in.deleted_tag_seen)
        || (events_in.read_deleted_cmd && events_in.normal_tag_seen);
    assign track_differs = events_in.id_track_valid && (id_track_in != internal_track_in);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mark_mismatch_reg <= 1'b0;
        end else if (mark_mismatch) begin
            mark_mismatch_reg <= 1'b1;
        end else if (cmd_start_in) begin
            mark_mismatch_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            data_crc_reg <= 1'b0;
        end else if (events_in.data_crc_err) begin
            data_crc_reg <= 1'b1;
        end else if (cmd_start_in) begin
            data_crc_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            track_mismatch_reg <= 1'b0;
        end else if (track_differs) begin
            track_mismatch_reg <= 1'b1;
        end else if (cmd_start_in) begin
            track_mismatch_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bad_track_reg <= 1'b0;
        end else if (track_differs && id_track_in == BAD_TRACK_NUMBER) begin
            bad_track_reg <= 1'b1;
        end else if (cmd_start_in) begin
            bad_track_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            data_tag_absent_reg <= 1'b0;
        end else if (events_in.no_data_tag) begin
            data_tag_absent_reg <= 1'b1;
        end else if (cmd_start_in) begin
            data_tag_absent_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // byte assembly
    // ------------------------------------------------------------
    status_first_t first_byte;
    status_second_t second_byte;
    status_third_t third_byte;
    status_fourth_t fourth_byte;

    always_comb begin
        first_byte.completion_code = code_reg;
        first_byte.positioning_done = seek_done_reg;
        first_byte.step_fault = step_fault_reg;
        first_byte.unused3 = UNUSED_ZERO;
        first_byte.head = head_select_pin_in;
        first_byte.drive_number = drive_number_in;
        second_byte.end_of_track = end_track_reg;
        second_byte.unused6 = UNUSED_ZERO;
        second_byte.crc_fault = crc_fault_reg;
        second_byte.overrun = overrun_reg;
        second_byte.unused3 = UNUSED_ZERO;
        second_byte.sector_missing = sector_missing_reg;
        second_byte.write_blocked = write_blocked_reg;
        second_byte.id_tag_absent = id_tag_absent_reg;
        third_byte.unused7 = UNUSED_ZERO;
        third_byte.deleted_flag_mismatch = mark_mismatch_reg;
        third_byte.data_field_crc_fault = data_crc_reg;
        third_byte.track_mismatch = track_mismatch_reg;
        third_byte.unused3 = UNUSED_ZERO;
        third_byte.unused2 = UNUSED_ZERO;
        third_byte.bad_track_flag = bad_track_reg;
        third_byte.data_tag_absent = data_tag_absent_reg;
        fourth_byte.unused7 = UNUSED_ZERO;
        fourth_byte.write_protect_status = wp_sync;
        fourth_byte.one5 = FOURTH_FIXED_ONE;
        fourth_byte.track_zero_status = track_zero_pin_sync;
        fourth_byte.one3 = FOURTH_FIXED_ONE;
        fourth_byte.head_select_status = head_select_pin_in;
        fourth_byte.drive_number = drive_number_in;
    end

    // ------------------------------------------------------------
    // result phase data port
    // ------------------------------------------------------------
    logic [7:0] selected_byte;
    logic read_take;

    always_comb begin
        if (result_select_in == SEL_FIRST) begin
            selected_byte = first_byte;
        end else if (result_select_in == SEL_SECOND) begin
            selected_byte = second_byte;
        end else if (result_select_in == SEL_THIRD) begin
            selected_byte = third_byte;
        end else begin
            selected_byte = fourth_byte;
        end
    end

    // host may read only with request and direction both set
    assign read_take = host_read_in && host_transfer_request_out && transfer_direction_out;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            result_data_out <= 8'h00;
        end else if (result_phase_in) begin
            result_data_out <= selected_byte;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            host_transfer_request_out <= 1'b0;
            transfer_direction_out <= 1'b0;
        end else begin
            host_transfer_request_out <= result_phase_in && !read_take;
            transfer_direction_out <= result_phase_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            result_done_out <= 1'b0;
        end else begin
            result_done_out <= read_take;
        end
    end

endmodule
`default_nettype wire

/* verification/result_status_checker_assertions.sv */
// Purpose: port-level checks of the result status bytes
// Assumes: one clock, synchronous active-high reset
// Notes: attached to the design by bind below
`timescale 1ns/1ns
`default_nettype none
module result_status_checker
    import result_status_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // observed inputs
    input wire logic result_phase_in,
    input wire logic [1:0] result_select_in,
    input wire logic head_select_pin_in,
    input wire logic [1:0] drive_number_in,
    input wire logic host_read_in,
    // observed outputs
    input wire logic [7:0] result_data_out,
    input wire logic host_transfer_request_out,
    input wire logic transfer_direction_out,
    input wire logic result_done_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic taken;
    assign taken = host_read_in & host_transfer_request_out & transfer_direction_out;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence read_taken;
        taken;
    endsequence
    sequence done_once;
        result_done_out ##1 !result_done_out;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    request_raise_a: assert property (result_phase_in && !taken |=> host_transfer_request_out)
        else $error("request not raised in result phase");
    idle_quiet_a: assert property (!result_phase_in |=> !host_transfer_request_out && !transfer_direction_out)
        else $error("request or direction outside result phase");
    direction_up_a: assert property (result_phase_in |=> transfer_direction_out)
        else $error("direction not toward host");
    request_drop_a: assert property (read_taken |=> !host_transfer_request_out)
        else $error("request held after read");
    done_pulse_a: assert property (read_taken |=> done_once)
        else $error("done not a single pulse after read");
    no_stray_done_a: assert property (!taken |=> !result_done_out)
        else $error("done without a read");
    data_hold_a: assert property (!result_phase_in |=> $stable(result_data_out))
        else $error("data changed outside result phase");
    first_layout_a: assert property (result_phase_in && result_select_in == SEL_FIRST |=>
        result_data_out[3] == 1'b0 && result_data_out[2:0] == {$past(head_select_pin_in), $past(drive_number_in)})
        else $error("first byte head or drive wrong");
    second_unused_a: assert property (result_phase_in && result_select_in == SEL_SECOND |=>
        result_data_out[6] == 1'b0 && result_data_out[3] == 1'b0)
        else $error("second byte unused bit set");
    third_unused_a: assert property (result_phase_in && result_select_in == SEL_THIRD |=>
        result_data_out[7] == 1'b0 && result_data_out[3:2] == 2'h0)
        else $error("third byte unused bit set");
    fourth_fixed_a: assert property (result_phase_in && result_select_in == SEL_FOURTH |=>
        result_data_out[7] == 1'b0 && result_data_out[5] && result_data_out[3] &&
        result_data_out[2:0] == {$past(head_select_pin_in), $past(drive_number_in)})
        else $error("fourth byte fixed bits wrong");
endmodule
bind disk_result_status_bytes result_status_checker i_result_status_checker (.*);
`default_nettype wire

/* verification/host_reader.sv */
// Purpose: host side that reads result bytes from the data port
// Assumes: host signals change after the falling edge
// Notes: bounded wait for request and direction
`timescale 1ns/1ns
`default_nettype none
module host_reader (
    // clock
    input wire logic sys_clk_in,
    // data port
    input wire logic host_transfer_request_in,
    input wire logic transfer_direction_in,
    input wire logic [7:0] result_data_in,
    output logic host_read_out
);
    initial host_read_out = 1'b0;
    // ------------------------------------------------------------
    // one byte read
    // ------------------------------------------------------------
    task automatic read_byte(output logic [7:0] b);
        int n;
        n = 0;
        @(negedge sys_clk_in);
        while (!(host_transfer_request_in === 1'b1 && transfer_direction_in === 1'b1) && n < 100) begin
            @(negedge sys_clk_in);
            n++;
        end
        host_read_out = 1'b1;
        @(posedge sys_clk_in);
        b = result_data_in;
        if (n >= 100) begin
            b = 8'hxx;
        end
        @(negedge sys_clk_in);
        host_read_out = 1'b0;
    endtask
endmodule
`default_nettype wire

/* verification/disk_result_status_bytes_tb.sv */
// Purpose: self-checking bench for the result status bytes
// Assumes: 20 MHz clock, inputs driven at the falling edge
// Notes: short step limit keeps recalibrate runs brief
`timescale 1ns/1ns
`default_nettype none
module disk_result_status_bytes_tb;
    import result_status_pkg::*;
    localparam int STEP = 4;
    logic sys_clk_in = 0, rst_in = 1, cmd_start_in = 0, recal_start_in = 0, result_phase_in = 0;
    logic [1:0] result_select_in = 0, drive_number_in = 0;
    status_events_t events_in = '0, ev;
    logic [7:0] sector_number_in = 0, id_track_in = 0, internal_track_in = 0, result_data_out;
    logic head_select_pin_in = 0, write_protect_pin_in = 0, track_zero_pin_in = 0, host_read_in;
    logic host_transfer_request_out, transfer_direction_out, result_done_out;
    logic [31:0] r;
    int fail_count = 0, checked = 0;
    disk_result_status_bytes #(.STEP_LIMIT(STEP)) i_disk_result_status_bytes (.*);
    host_reader i_host_reader (.sys_clk_in(sys_clk_in), .host_transfer_request_in(host_transfer_request_out),
        .transfer_direction_in(transfer_direction_out), .result_data_in(result_data_out),
        .host_read_out(host_read_in));
    initial forever #25 sys_clk_in = ~sys_clk_in;
    // ------------------------------------------------------------
    // expectation and checking
    // ------------------------------------------------------------
    function automatic logic [31:0] expect_bytes(status_events_t e, logic sf);
        logic [1:0] code;
        logic mis;
        code = e.cmd_invalid ? CODE_INVALID : e.poll_abnormal ? CODE_POLLING :
            e.exec_abnormal ? CODE_ABNORMAL : CODE_NORMAL;
        mis = e.id_track_valid && id_track_in != internal_track_in;
        return {code, e.seek_done, sf, 1'b0, head_select_pin_in, drive_number_in,
            (e.sector_access && sector_number_in == LAST_SECTOR_NUMBER) | e.rw_end_no_tc, 1'b0,
            e.id_crc_err | e.data_crc_err, e.service_late, 1'b0,
            e.sector_not_found | e.id_read_fail | e.track_sequence_err,
            e.write_cmd_active & write_protect_pin_in, e.no_id_after_two_index | e.no_data_tag,
            1'b0, (e.read_data_cmd & e.deleted_tag_seen) | (e.read_deleted_cmd & e.normal_tag_seen),
            e.data_crc_err, mis, 2'h0, mis && id_track_in == BAD_TRACK_NUMBER, e.no_data_tag,
            1'b0, write_protect_pin_in, 1'b1, track_zero_pin_in, 1'b1, head_select_pin_in, drive_number_in};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // one command with its result phase
    // ------------------------------------------------------------
    task automatic run_cmd(input status_events_t e, input int steps);
        logic [31:0] exp;
        logic [7:0] b;
        @(negedge sys_clk_in);
        cmd_start_in = 1;
        recal_start_in = 1;
        @(negedge sys_clk_in);
        cmd_start_in = 0;
        recal_start_in = 0;
        repeat (3) @(negedge sys_clk_in);
        for (int i = 0; i < steps; i++) begin
            events_in.recal_step = 1;
            @(negedge sys_clk_in);
            events_in = '0;
            @(negedge sys_clk_in);
        end
        events_in = e;
        @(negedge sys_clk_in);
        events_in = '0;
        result_phase_in = 1;
        exp = expect_bytes(e, e.outward_past_zero | (steps >= STEP && !track_zero_pin_in));
        for (int i = 0; i < RESULT_BYTE_COUNT; i++) begin
            result_select_in = 2'(i);
            i_host_reader.read_byte(b);
            check(b, exp[31 - 8 * i -: 8]);
        end
        result_phase_in = 0;
        result_select_in = SEL_FIRST;
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h2641e2aa));
        repeat (8) @(negedge sys_clk_in);
        rst_in = 0;
        for (int c = 0; c < 4; c++) begin
            ev = '0;
            ev.exec_abnormal = c == 1;
            ev.cmd_invalid = c == 2;
            ev.poll_abnormal = c == 3;
            run_cmd(ev, 0);
        end
        sector_number_in = 8'hfe;
        internal_track_in = 8'h05;
        id_track_in = 8'hff;
        ev = '0;
        ev.sector_access = 1;
        ev.id_track_valid = 1;
        run_cmd(ev, 0);
        sector_number_in = 8'hff;
        run_cmd(ev, STEP - 1);
        run_cmd('0, STEP);
        track_zero_pin_in = 1;
        run_cmd('0, STEP);
        for (int k = 0; k < 40; k++) begin
            @(negedge sys_clk_in);
            r = $urandom;
            {write_protect_pin_in, track_zero_pin_in, head_select_pin_in, drive_number_in} = r[4:0];
            sector_number_in = r[31:24];
            id_track_in = r[23:16];
            internal_track_in = r[5] ? r[23:16] : r[15:8];
            r = $urandom;
            ev = r[$bits(status_events_t)-1:0];
            ev.recal_step = 0;
            run_cmd(ev, 0);
        end
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
